// >>> hw/tsx_defs.svh
// Purpose: Constants of the timing I/O status exchange block.
// Assumes: 32-bit Avalon-MM words, byte addresses, 25 MHz clk_sys.
// Notes:   Types live in tsx_pkg.
//
// What this block does
// - Three groups: board command, results, line command
// - Board command carries crank angle and enable
// - Line command: thresholds, switch drives, line disables
// - Enable low stops acquisition of results and level; runs continue
// - Every-interval mode transfers every run
// - Data-dependent mode transfers only changed values
// - Periodic run every configured interval in ms
// - Return 64 measured values, index 0 to 63
// - Each value has a companion timeout code
// - Low flag word: bit n updated value n
// - High flag word: bit n is value 32+n
// - Level word bit i is comparator result i
// - Codes: 0 ok, 1 timeout, 2 unused
// - Disabled line with check reports timeout
`ifndef TSX_DEFS_SVH
`define TSX_DEFS_SVH

// Register byte offsets
`define TSX_REG_CTRL      12'h000
`define TSX_REG_ANGLE     12'h004
`define TSX_REG_INTERVAL  12'h008
`define TSX_REG_USED_LO   12'h00c
`define TSX_REG_USED_HI   12'h010
`define TSX_REG_FLAGS_LO  12'h014
`define TSX_REG_FLAGS_HI  12'h018
`define TSX_REG_LEVEL     12'h01c
`define TSX_REG_IRQ_STS   12'h020
`define TSX_REG_IRQ_MASK  12'h024
`define TSX_REG_RUNS      12'h028
`define TSX_REG_DISABLE   12'h02c
// Array windows, selected by address bits 11:8
`define TSX_WIN_THRESH    4'h1
`define TSX_WIN_SWITCH    4'h2
`define TSX_WIN_RESULT    4'h4
`define TSX_WIN_CODE      4'h5

// Control fields
`define TSX_CTRL_EN       0
`define TSX_CTRL_MODE     1

// Interrupt status bits
`define TSX_IRQ_RUN       0
`define TSX_IRQ_XFER      1
`define TSX_IRQ_TMO       2

// Stale result codes
`define TSX_CODE_OK       2'h0
`define TSX_CODE_TMO      2'h1
`define TSX_CODE_UNUSED   2'h2

// Reset values
`define TSX_INTERVAL_RST  16'h000a
`define TSX_USED_RST      32'hffffffff

// Timing
`define TSX_CLK_HZ        25000000
`define TSX_TICK_MS       1
`define TSX_MS_CYCLES     (`TSX_CLK_HZ / 1000 * `TSX_TICK_MS)

`endif

// >>> hw/tsx_pkg.sv
// Purpose: Types of the timing I/O status exchange block.
// Assumes: Constants come from tsx_defs.svh.
// Notes:   Mode encoding follows the control bit.
package tsx_pkg;
   typedef enum logic {TSX_EVERY, TSX_DATA} tsx_mode_t;
   typedef logic [1:0]  tsx_code_t;
   typedef logic [31:0] tsx_word_t;
endpackage

// >>> hw/tsx_top.sv
// Purpose: Status exchange between the real-time model and the timing board.
// Assumes: Measurement engine delivers results as single-cycle strobes.
// Notes:   Published results change only at a calculation run.
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`include "tsx_defs.svh"

module tsx_top #(
   parameter int MS_CYCLES = `TSX_MS_CYCLES
) (
   input  wire logic                      clk_sys,
   input  wire logic                      nrst,
   input  wire logic [11:0]               avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [3:0]                avs_byteenable,
   input  wire tsx_pkg::tsx_word_t        avs_writedata,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest,
   output logic                           irq,
   input  wire logic                      meas_strobe,
   input  wire logic [5:0]                meas_index,
   input  wire tsx_pkg::tsx_word_t        meas_value,
   input  wire logic                      meas_timeout,
   input  wire logic [4:0]                meas_line,
   input  wire logic                      meas_checked,
   input  wire logic [31:0]               cmp_level_raw,
   output logic                           eval_enable,
   output logic      [31:0]               crank_angle,
   output logic      [31:0][15:0]         comparator_threshold_setting,
   output logic      [15:0][2:0]          switch_drive_setting,
   output logic      [31:0]               line_disable_control,
   output logic                           run_strobe,
   output logic                           xfer_strobe
);
   import tsx_pkg::*;

   // Merge a write under byte enables
   function automatic tsx_word_t be_merge(input tsx_word_t old_v,
                                          input tsx_word_t new_v,
                                          input logic [3:0] be);
      tsx_word_t r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Unused beats timeout; a seen timeout and disabled-with-check both give timeout
   function automatic tsx_code_t code_of(input logic used_bit,
                                         input logic tmo,
                                         input logic dis_chk);
      if (!used_bit) begin
         return `TSX_CODE_UNUSED;
      end
      return (tmo || dis_chk) ? `TSX_CODE_TMO : `TSX_CODE_OK;
   endfunction

   // Software visible state
   logic [1:0]           ctrl;
   logic [15:0]          interval;
   logic [63:0]          used;
   logic [31:0]          flags_lo;
   logic [31:0]          flags_hi;
   logic [31:0]          level;
   logic [2:0]           sts;
   logic [2:0]           mask;
   logic [31:0]          run_cnt;

   // Pending and published results
   tsx_word_t            pend_val [64];
   logic [4:0]           pend_chn [64];
   logic [63:0]          pend_upd;
   logic [63:0]          pend_tmo;
   logic [63:0]          pend_chk;
   tsx_word_t            pub_val  [64];
   tsx_code_t            pub_code [64];

   // Timing
   logic [31:0]          ms_cnt;
   logic [15:0]          ivl_cnt;

   // Bus decode
   wire                  req      = avs_read | avs_write;
   wire                  acc      = req & ~avs_waitrequest;
   wire                  wr_acc   = acc & avs_write;
   wire                  rd_acc   = acc & avs_read;
   wire [3:0]            win      = avs_address[11:8];
   wire [5:0]            widx     = avs_address[7:2];
   wire                  is_reg   = (win == 4'h0);
   wire                  wr_ctrl  = wr_acc & (avs_address == `TSX_REG_CTRL);
   wire                  wr_ang   = wr_acc & (avs_address == `TSX_REG_ANGLE);
   wire                  wr_ivl   = wr_acc & (avs_address == `TSX_REG_INTERVAL);
   wire                  wr_ulo   = wr_acc & (avs_address == `TSX_REG_USED_LO);
   wire                  wr_uhi   = wr_acc & (avs_address == `TSX_REG_USED_HI);
   wire                  wr_mask  = wr_acc & (avs_address == `TSX_REG_IRQ_MASK);
   wire                  wr_dis   = wr_acc & (avs_address == `TSX_REG_DISABLE);
   wire                  wr_thr   = wr_acc & (win == `TSX_WIN_THRESH) & ~widx[5];
   wire                  wr_sw    = wr_acc & (win == `TSX_WIN_SWITCH) & (widx[5:4] == 2'h0);
   wire                  rd_sts   = rd_acc & (avs_address == `TSX_REG_IRQ_STS);
   wire tsx_word_t       wmerge   = be_merge(32'h00000000, avs_writedata, avs_byteenable);

   // Mode and enable; enable low stops evaluation
   wire tsx_mode_t       mode     = tsx_mode_t'(ctrl[`TSX_CTRL_MODE]);
   wire                  eval_on  = ctrl[`TSX_CTRL_EN];
   wire                  take_in  = meas_strobe & eval_on;

   // Run scheduler: millisecond tick, then interval in ms
   wire                  ms_tick  = (ms_cnt == 32'(MS_CYCLES - 1));
   wire [15:0]           ivl_top  = (interval == 16'h0000) ? 16'h0000 : interval - 16'h0001;
   wire                  run      = ms_tick & (ivl_cnt >= ivl_top);

   // Per-value decisions for this run
   tsx_code_t            next_code [64];
   logic [63:0]          take;
   logic [63:0]          next_flag;
   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_val
         // Disabled line under timeout check forces a timeout
         assign next_code[g] = code_of(used[g], pend_tmo[g],
                                       pend_chk[g] & line_disable_control[pend_chn[g]]);
         // Change is judged against the published copy, not the last calculation
         assign take[g]      = (mode == TSX_EVERY) ? 1'b1 :
                               ((pend_val[g] != pub_val[g]) ||
                                (next_code[g] != pub_code[g]));
         assign next_flag[g] = (mode == TSX_EVERY) ? pend_upd[g] : take[g];
      end
   endgenerate

   wire                  lvl_chg   = eval_on & (cmp_level_raw != level);
   wire                  any_xfer  = (mode == TSX_EVERY) | (|take) | lvl_chg;
   wire                  any_tmo   = |pend_tmo;
   wire [2:0]            sts_set   = {run & any_tmo, run & any_xfer, run};
   // Clear only what the read reported; a bit set after the snapshot survives
   wire [2:0]            sts_clr   = rd_sts ? avs_readdata[2:0] : 3'h0;
   // Set wins over the read clear
   wire [2:0]            next_sts  = (sts & ~sts_clr) | sts_set;

   // Read mux; unmapped addresses read zero
   wire [31:0]           rd_reg =
      (avs_address == `TSX_REG_CTRL)     ? {30'h00000000, ctrl} :
      (avs_address == `TSX_REG_ANGLE)    ? crank_angle :
      (avs_address == `TSX_REG_INTERVAL) ? {16'h0000, interval} :
      (avs_address == `TSX_REG_USED_LO)  ? used[31:0] :
      (avs_address == `TSX_REG_USED_HI)  ? used[63:32] :
      (avs_address == `TSX_REG_FLAGS_LO) ? flags_lo :
      (avs_address == `TSX_REG_FLAGS_HI) ? flags_hi :
      (avs_address == `TSX_REG_LEVEL)    ? level :
      (avs_address == `TSX_REG_IRQ_STS)  ? {29'h00000000, sts} :
      (avs_address == `TSX_REG_IRQ_MASK) ? {29'h00000000, mask} :
      (avs_address == `TSX_REG_RUNS)     ? run_cnt :
      (avs_address == `TSX_REG_DISABLE)  ? line_disable_control : 32'h00000000;
   wire [31:0]           rd_mux =
      is_reg                                  ? rd_reg :
      (win == `TSX_WIN_RESULT)                ? pub_val[widx] :
      (win == `TSX_WIN_CODE)                  ? {30'h00000000, pub_code[widx]} :
      (wr_thr | ((win == `TSX_WIN_THRESH) & ~widx[5])) ?
         {16'h0000, comparator_threshold_setting[widx[4:0]]} :
      ((win == `TSX_WIN_SWITCH) & (widx[5:4] == 2'h0)) ?
         {29'h00000000, switch_drive_setting[widx[3:0]]} : 32'h00000000;

   // One wait cycle per request, data ready when wait drops
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (req & avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Board and line command registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl                 <= 2'h0;
         crank_angle          <= 32'h00000000;
         interval             <= `TSX_INTERVAL_RST;
         used                 <= {`TSX_USED_RST, `TSX_USED_RST};
         mask                 <= 3'h0;
         line_disable_control <= 32'h00000000;
      end else begin
         if (wr_ctrl) ctrl <= 2'(be_merge({30'h00000000, ctrl}, avs_writedata,
                                          avs_byteenable));
         if (wr_ang) crank_angle <= be_merge(crank_angle, avs_writedata,
                                             avs_byteenable);
         if (wr_ivl) interval <= 16'(be_merge({16'h0000, interval}, avs_writedata,
                                              avs_byteenable));
         if (wr_ulo) used[31:0] <= be_merge(used[31:0], avs_writedata, avs_byteenable);
         if (wr_uhi) used[63:32] <= be_merge(used[63:32], avs_writedata, avs_byteenable);
         if (wr_mask) mask <= wmerge[2:0];
         if (wr_dis) line_disable_control <= be_merge(line_disable_control, avs_writedata,
                                                      avs_byteenable);
      end
   end

   // Threshold and switch drive windows
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         comparator_threshold_setting <= '0;
         switch_drive_setting         <= '0;
      end else begin
         if (wr_thr) comparator_threshold_setting[widx[4:0]] <=
            16'(be_merge({16'h0000, comparator_threshold_setting[widx[4:0]]},
                         avs_writedata, avs_byteenable));
         if (wr_sw) switch_drive_setting[widx[3:0]] <= wmerge[2:0];
      end
   end

   // Run timing; an interval of zero acts as one ms
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ms_cnt  <= 32'h00000000;
         ivl_cnt <= 16'h0000;
      end else begin
         ms_cnt <= ms_tick ? 32'h00000000 : ms_cnt + 32'h00000001;
         if (run) begin
            ivl_cnt <= 16'h0000;
         end else if (ms_tick) begin
            ivl_cnt <= ivl_cnt + 16'h0001;
         end
      end
   end

   // Collect strobed results; a strobe in a run cycle stays pending
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pend_upd <= 64'h0000000000000000;
         pend_tmo <= 64'h0000000000000000;
         pend_chk <= 64'h0000000000000000;
         for (int i = 0; i < 64; i++) begin
            pend_val[i] <= 32'h00000000;
            pend_chn[i] <= 5'h00;
         end
      end else begin
         if (run) begin
            pend_upd <= 64'h0000000000000000;
         end
         if (take_in) begin
            pend_val[meas_index] <= meas_value;
            pend_chn[meas_index] <= meas_line;
            pend_upd[meas_index] <= 1'b1;
            pend_tmo[meas_index] <= meas_timeout;
            pend_chk[meas_index] <= meas_checked;
         end
      end
   end

   // Publish every result of one run together
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         flags_lo <= 32'h00000000;
         flags_hi <= 32'h00000000;
         level    <= 32'h00000000;
         run_cnt  <= 32'h00000000;
         for (int i = 0; i < 64; i++) begin
            pub_val[i]  <= 32'h00000000;
            pub_code[i] <= `TSX_CODE_OK;
         end
      end else if (run) begin
         flags_lo <= next_flag[31:0];
         flags_hi <= next_flag[63:32];
         run_cnt  <= run_cnt + 32'h00000001;
         if (eval_on) begin
            level <= cmp_level_raw;
         end
         for (int i = 0; i < 64; i++) begin
            if (take[i]) begin
               pub_val[i]  <= pend_val[i];
               pub_code[i] <= next_code[i];
            end
         end
      end
   end

   // Interrupt, link strobes and mirrored outputs
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sts         <= 3'h0;
         irq         <= 1'b0;
         run_strobe  <= 1'b0;
         xfer_strobe <= 1'b0;
         eval_enable <= 1'b0;
      end else begin
         sts         <= next_sts;
         irq         <= |(next_sts & mask);
         run_strobe  <= run;
         xfer_strobe <= run & any_xfer;
         eval_enable <= eval_on;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Bus handshake and enable gating
   chk_bus_one_wait: assert property ((req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("waitrequest did not drop after one cycle");
   chk_enable_freezes: assert property ((!eval_on && !run) |=> $stable(pend_upd))
      else $error("pending results changed while evaluation disabled");

   // Flag words and transfers per mode, run count and level sampling
   chk_every_flags_lo: assert property (
         (run && mode == TSX_EVERY) |=> flags_lo == $past(pend_upd[31:0]))
      else $error("low flag word wrong in every-interval mode");
   chk_every_xfer: assert property ((run && mode == TSX_EVERY) |=> xfer_strobe)
      else $error("every-interval run without transfer strobe");
   chk_data_no_change: assert property (
         (run && mode == TSX_DATA && pend_val[0] == pub_val[0]
          && next_code[0] == pub_code[0]) |=> !flags_lo[0])
      else $error("unchanged value flagged in data mode");
   chk_data_last_sent: assert property (
         (run && mode == TSX_DATA && pend_val[8] != pub_val[8])
         |=> (pub_val[8] == $past(pend_val[8])) && flags_lo[8])
      else $error("changed value not transferred");
   chk_run_count: assert property (run |=> run_cnt == $past(run_cnt) + 32'h00000001 ##1 !run)
      else $error("run counter or run spacing wrong");
   chk_every_flags_hi: assert property (
         (run && mode == TSX_EVERY) |=> flags_hi == $past(pend_upd[63:32]))
      else $error("high flag word wrong in every-interval mode");
   chk_level_sample: assert property ((run && eval_on) |=> level == $past(cmp_level_raw))
      else $error("level word not sampled at run");

   // Codes, events and result reads
   chk_unused_code: assert property (
         (run && !used[63] && mode == TSX_EVERY) |=> pub_code[63] == `TSX_CODE_UNUSED)
      else $error("unused value not coded unused");
   chk_disabled_tmo: assert property (
         (run && mode == TSX_EVERY && used[5] && pend_chk[5]
          && line_disable_control[pend_chn[5]]) |=> pub_code[5] == `TSX_CODE_TMO)
      else $error("disabled checked line did not time out");
   chk_tmo_status: assert property ((run && any_tmo) |=> sts[`TSX_IRQ_TMO])
      else $error("pending timeout did not raise status");
   chk_run_event: assert property (run |=> sts[`TSX_IRQ_RUN] && run_strobe)
      else $error("run did not raise status and strobe");
   chk_result_read: assert property (
         (req && avs_waitrequest && avs_read && win == `TSX_WIN_RESULT)
         |=> avs_readdata == $past(pub_val[widx]))
      else $error("result read returned wrong data");

endmodule

// >>> sim/tsx_meas_model.sv
// Purpose: Stand-in for the measurement engine that feeds result strobes.
// Assumes: send is called right after a rising edge of clk_sys.
// Notes:   Between strobes the value lines show the inverse of the last value.
`timescale 1ns/100ps
module tsx_meas_model (
   input  wire logic         clk_sys,
   output logic              meas_strobe,
   output logic [5:0]        meas_index,
   output tsx_pkg::tsx_word_t meas_value,
   output logic              meas_timeout,
   output logic [4:0]        meas_line,
   output logic              meas_checked
);
   import tsx_pkg::*;

   // Idle lines at time zero
   initial begin
      meas_strobe  = 1'b0;
      meas_index   = 6'h00;
      meas_value   = 32'h00000000;
      meas_timeout = 1'b0;
      meas_line    = 5'h00;
      meas_checked = 1'b0;
   end

   // One-cycle strobe, then stale index, value and timeout turned over so they never look valid
   task send(input logic [5:0] i, input logic [31:0] v, input logic t,
             input logic [4:0] l, input logic k);
      meas_strobe  <= 1'b1;
      meas_index   <= i;
      meas_value   <= v;
      meas_timeout <= t;
      meas_line    <= l;
      meas_checked <= k;
      @(posedge clk_sys);
      meas_strobe  <= 1'b0;
      meas_index   <= ~i;
      meas_value   <= ~v;
      meas_timeout <= ~t;
      @(posedge clk_sys);
   endtask
endmodule

// >>> sim/tb_top.sv
// Purpose: Self-checking bench of the status exchange block.
// Assumes: One run every 200 clocks once the interval is set to 1.
// Notes:   Reference model mirrors every run seen on run_strobe.
`timescale 1ns/100ps
module tb_top;
   import tsx_pkg::*;
   logic              clk_sys = 1'b0;
   logic              nrst = 1'b0;
   logic [11:0]       avs_address = 12'h000;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   tsx_word_t         avs_writedata = 32'h0;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest, irq, eval_enable, run_strobe, xfer_strobe;
   logic              meas_strobe, meas_timeout, meas_checked;
   logic [5:0]        meas_index;
   tsx_word_t         meas_value;
   logic [4:0]        meas_line;
   logic [31:0]       cmp_level_raw = 32'h0;
   logic [31:0]       crank_angle, line_disable_control;
   logic [31:0][15:0] comparator_threshold_setting;
   logic [15:0][2:0]  switch_drive_setting;
   logic [31:0]       pend_v[64] = '{default: 0};
   logic [31:0]       pub_v[64] = '{default: 0};
   logic [1:0]        pub_c[64] = '{default: 0};
   logic              pend_t[64] = '{default: 0};
   logic              pend_k[64] = '{default: 0};
   logic [4:0]        pend_l[64] = '{default: 0};
   logic [63:0]       strobed = '0, flags = '0, used = '1;
   logic [31:0]       ctrl = 32'h0, dis = 32'h0, lvl_pub = 32'h0, q;
   logic              xfer_exp, xfer_seen, irq_seen;
   int                errors = 0, num_checks = 0, cyc = 0;
   int                ids[9] = '{0, 31, 32, 63, 5, 6, 3, 8, 9};

   always #20 clk_sys = ~clk_sys;

   tsx_top #(.MS_CYCLES(200)) tsx_top_i (.clk_sys(clk_sys), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(4'hf), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .meas_strobe(meas_strobe),
      .meas_index(meas_index), .meas_value(meas_value), .meas_timeout(meas_timeout),
      .meas_line(meas_line), .meas_checked(meas_checked), .cmp_level_raw(cmp_level_raw),
      .eval_enable(eval_enable), .crank_angle(crank_angle),
      .comparator_threshold_setting(comparator_threshold_setting),
      .switch_drive_setting(switch_drive_setting),
      .line_disable_control(line_disable_control), .run_strobe(run_strobe),
      .xfer_strobe(xfer_strobe));

   tsx_meas_model tsx_meas_model_i (.clk_sys(clk_sys), .meas_strobe(meas_strobe),
      .meas_index(meas_index), .meas_value(meas_value), .meas_timeout(meas_timeout),
      .meas_line(meas_line), .meas_checked(meas_checked));

   task conclude;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask

   // Avalon cycle: held until waitrequest is sampled low; only the cycle limit ends a wait
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      if (w && a == 12'h000) ctrl = d;
      if (w && a == 12'h02c) dis = d;
      if (w && a == 12'h010) used[63:32] = d;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task rchk(input string s, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(s, q, e);
   endtask

   // Strobes while disabled never reach the model, as the block drops them
   task snd(input int i, input logic [31:0] v, input logic t, input logic [4:0] l,
            input logic k);
      if (ctrl[0]) begin
         pend_v[i]  = v;
         pend_t[i]  = t;
         pend_l[i]  = l;
         pend_k[i]  = k;
         strobed[i] = 1'b1;
      end
      tsx_meas_model_i.send(6'(i), v, t, l, k);
   endtask

   // Reference run: codes, copy policy per mode, flags and level
   function automatic void model_run();
      logic [1:0] c;
      logic       chg;
      xfer_exp = !ctrl[1] || (ctrl[0] && cmp_level_raw != lvl_pub);
      for (int i = 0; i < 64; i++) begin
         c = !used[i] ? 2'h2 : (pend_t[i] || (pend_k[i] && dis[pend_l[i]])) ? 2'h1 : 2'h0;
         chg = pend_v[i] != pub_v[i] || c != pub_c[i];
         flags[i] = ctrl[1] ? chg : strobed[i];
         xfer_exp = xfer_exp || flags[i];
         if (!ctrl[1] || chg) pub_v[i] = pend_v[i];
         if (!ctrl[1] || chg) pub_c[i] = c;
      end
      strobed = '0;
      if (ctrl[0]) lvl_pub = cmp_level_raw;
   endfunction

   // Cycle limit and model tracking of every run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         conclude();
      end
      if (run_strobe === 1'b1) model_run();
   end

   task wait_run;
      do begin
         @(posedge clk_sys);
      end while (run_strobe !== 1'b1);
      xfer_seen = xfer_strobe;
      irq_seen  = irq;
      @(posedge clk_sys);
   endtask

   task check_all;
      rchk("flags_lo", 12'h014, flags[31:0]);
      rchk("flags_hi", 12'h018, flags[63:32]);
      rchk("level", 12'h01c, lvl_pub);
      chk("xfer", {31'h0, xfer_seen}, {31'h0, xfer_exp});
      foreach (ids[k]) begin
         rchk("result", 12'h400 + 12'(4 * ids[k]), pub_v[ids[k]]);
         rchk("code", 12'h500 + 12'(4 * ids[k]), {30'h0, pub_c[ids[k]]});
      end
   endtask

   initial begin
      void'($urandom(32'hbaba4dda));
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rchk("interval", 12'h008, 32'h0000000a);
      rchk("used_lo", 12'h00c, 32'hffffffff);
      rchk("unmapped", 12'h0fc, 32'h0);
      chk("enable_rst", {31'h0, eval_enable}, 32'h0);
      $display("test reset done");
      bus(1'b1, 12'h008, 32'h1);
      bus(1'b1, 12'h010, 32'h7fffffff);
      bus(1'b1, 12'h02c, 32'h80);
      bus(1'b1, 12'h004, 32'h000002d0);
      bus(1'b1, 12'h000, 32'h1);
      bus(1'b1, 12'h17c, 32'h0000beef);
      bus(1'b1, 12'h23c, 32'h4);
      chk("enable", {31'h0, eval_enable}, 32'h1);
      chk("angle", crank_angle, 32'h000002d0);
      chk("thresh", {16'h0, comparator_threshold_setting[31]}, 32'h0000beef);
      chk("switch", {29'h0, switch_drive_setting[15]}, 32'h4);
      chk("disable", line_disable_control, 32'h80);
      wait_run();
      cmp_level_raw <= $urandom();
      for (int k = 0; k < 6; k++) snd(ids[k], $urandom(), k == 5, 5'((k == 4) ? 7 : k), k == 4);
      wait_run();
      check_all();
      $display("test every done");
      bus(1'b1, 12'h000, 32'h3);
      wait_run();
      snd(3, $urandom(), 1'b0, 5'd3, 1'b0);
      snd(3, pub_v[3], 1'b0, 5'd3, 1'b0);
      snd(8, $urandom(), 1'b0, 5'd0, 1'b0);
      snd(0, pub_v[0], 1'b0, 5'd0, 1'b0);
      wait_run();
      check_all();
      $display("test change done");
      bus(1'b1, 12'h000, 32'h0);
      wait_run();
      cmp_level_raw <= ~lvl_pub;
      snd(9, $urandom(), 1'b1, 5'd9, 1'b0);
      wait_run();
      check_all();
      $display("test disable done");
      bus(1'b1, 12'h024, 32'h1);
      wait_run();
      chk("irq_on", {31'h0, irq_seen}, 32'h1);
      bus(1'b0, 12'h020, 32'h0);
      chk("sts", {29'h0, q[2:0]}, 32'h7);
      bus(1'b1, 12'h024, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("irq_off", {31'h0, irq}, 32'h0);
      $display("test irq done");
      conclude();
   end
endmodule
